// ==== hw/rrx_data_path.sv ====
// receive data path of the remote-control receiver: shifter, count, holding byte
`default_nettype none
module rrx_data_path (
  input wire logic clk,
  input wire logic reset,
  input wire logic bitValid,
  input wire logic bitValue,
  input wire logic frameEnd,
  input wire logic frameError,
  input wire logic [rrx_pkg::RRX_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  output logic byteFull,
  output logic irq
);
  import rrx_pkg::*;

  function automatic logic hit(input logic [RRX_ADDR_W-1:0] a,
    input logic [RRX_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] hold_reg;
  logic [7:0] hold_next;
  logic full_reg;
  logic full_next;
  rrx_frame_t frame_reg;
  rrx_frame_t frame_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic enable;
  logic shiftRd;
  logic [7:0] shifted;

  rrx_core_if core ();

  assign enable = ctrl_reg[RRX_CTRL_EN];
  assign shiftRd = regRd && hit(regAddr, RRX_OFF_SHIFT);

  // control register: only the enable bit is kept
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (regWr && hit(regAddr, RRX_OFF_CTRL))
      ctrl_next = {7'h00, regWrData[RRX_CTRL_EN]};
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      ctrl_reg <= RRX_RST_CTRL;
    else
      ctrl_reg <= ctrl_next;
  end

  always_comb
  begin
    shift_next = shift_reg;
    count_next = count_reg;
    hold_next = hold_reg;
    full_next = 1'b0;
    frame_next = frame_reg;
    // new bit enters at the top
    shifted = {bitValue, shift_reg[7:1]};
    if (!enable)
    begin
      // disabled, holding byte forced to zero
      hold_next = RRX_RST_BYTE;
      count_next = RRX_RST_COUNT;
      shift_next = RRX_RST_SHIFT;
      frame_next = RRX_IDLE;
    end
    else
    begin
      if (bitValid)
      begin
        frame_next = RRX_RECV;
        if (count_reg == RRX_LAST_BIT)
        begin
          // eighth bit moves byte to holding
          // earliest bit has reached bit 0
          // no guard against an unread byte
          hold_next = shifted;
          shift_next = RRX_RST_SHIFT;
          count_next = RRX_RST_COUNT;
          full_next = 1'b1;
        end
        else
        begin
          shift_next = shifted;
          count_next = count_reg + 8'h01;
        end
      end
      if (frameEnd)
        frame_next = RRX_ENDED;
      if (frameError)
      begin
        count_next = RRX_RST_COUNT;
        shift_next = RRX_RST_SHIFT;
        frame_next = RRX_IDLE;
      end
      // shifter read after end clears count
      else if (shiftRd && frame_reg == RRX_ENDED)
      begin
        count_next = RRX_RST_COUNT;
        shift_next = RRX_RST_SHIFT;
        frame_next = RRX_IDLE;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      hold_reg <= RRX_RST_BYTE;
      count_reg <= RRX_RST_COUNT;
      shift_reg <= RRX_RST_SHIFT;
      full_reg <= 1'b0;
      frame_reg <= RRX_IDLE;
    end
    else
    begin
      hold_reg <= hold_next;
      count_reg <= count_next;
      shift_reg <= shift_next;
      full_reg <= full_next;
      frame_reg <= frame_next;
    end
  end

  assign byteFull = full_reg;

  // events go to the sticky status as they happen
  assign core.evt[RRX_EV_FULL] = full_next;
  assign core.evt[RRX_EV_END] = frameEnd && enable;
  assign core.evt[RRX_EV_ERR] = frameError && enable;
  assign core.wrStatus = regWr && hit(regAddr, RRX_OFF_STATUS);
  assign core.wrMask = regWr && hit(regAddr, RRX_OFF_MASK);
  assign core.wrData = regWrData;
  // holding and count have no write path
  assign core.rdStrobe = regRd;
  assign core.rdAddr = regAddr;
  assign core.holdVal = hold_reg;
  assign core.countVal = count_reg;
  assign core.shiftVal = shift_reg;
  assign core.ctrlVal = ctrl_reg;
  assign regRdData = core.rdData;

  rrx_irq_status #(
    .NUM_EV(RRX_NUM_EV)
  ) u_irq (
    .clk(clk),
    .reset(reset),
    .bus(core.irqm),
    .irq(irq)
  );

  rrx_read_port u_rd (
    .clk(clk),
    .reset(reset),
    .bus(core.rdm)
  );

  // quiet cycle for the shift path: enabled, no error clear, no read clear
  logic quiet;
  assign quiet = enable && !frameError && !(shiftRd && frame_reg == RRX_ENDED);

  property p_transfer;
    @(posedge clk) disable iff (reset)
    enable && bitValid && count_reg == RRX_LAST_BIT
      |=> hold_reg == {$past(bitValue), $past(shift_reg[7:1])};
  endproperty
  a_transfer: assert property (p_transfer)
    else $error("holding byte not loaded from shifter");

  property p_first_bit_low;
    @(posedge clk) disable iff (reset)
    quiet && bitValid && count_reg == 8'h00 && !frameEnd
      ##1 (quiet && bitValid) [*7]
      |=> hold_reg[0] == $past(bitValue, 8);
  endproperty
  a_first_bit_low: assert property (p_first_bit_low)
    else $error("earliest bit not at bit 0");

  property p_full_with_transfer;
    @(posedge clk) disable iff (reset)
    $changed(hold_reg) && enable && $past(enable) |-> byteFull;
  endproperty
  a_full_with_transfer: assert property (p_full_with_transfer)
    else $error("byte-full not raised with the transfer");

  property p_full_cause;
    @(posedge clk) disable iff (reset)
    byteFull |-> $past(bitValid && enable && count_reg == RRX_LAST_BIT)
      && count_reg == 8'h00 && shift_reg == 8'h00;
  endproperty
  a_full_cause: assert property (p_full_cause)
    else $error("byte-full without an eighth bit");

  property p_reset_clear;
    @(posedge clk)
    reset |=> hold_reg == 8'h00 && count_reg == 8'h00 && !byteFull;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset left holding byte or count set");

  property p_disabled_zero;
    @(posedge clk) disable iff (reset)
    !enable |=> hold_reg == 8'h00 && count_reg == 8'h00;
  endproperty
  a_disabled_zero: assert property (p_disabled_zero)
    else $error("disabled receiver kept data");

  property p_overwrite;
    @(posedge clk) disable iff (reset)
    enable && bitValid && count_reg == RRX_LAST_BIT && core.statusVal[RRX_EV_FULL]
      |=> byteFull && hold_reg == {$past(bitValue), $past(shift_reg[7:1])};
  endproperty
  a_overwrite: assert property (p_overwrite)
    else $error("second byte was held back");

  property p_count_step;
    @(posedge clk) disable iff (reset)
    quiet && bitValid && count_reg < RRX_LAST_BIT
      |=> count_reg == $past(count_reg) + 8'h01;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("bit count did not step");

  property p_count_hold;
    @(posedge clk) disable iff (reset)
    quiet && !bitValid |=> $stable(count_reg) && $stable(shift_reg);
  endproperty
  a_count_hold: assert property (p_count_hold)
    else $error("count moved without a bit");

  property p_shift_in;
    @(posedge clk) disable iff (reset)
    quiet && bitValid && count_reg < RRX_LAST_BIT
      |=> shift_reg == {$past(bitValue), $past(shift_reg[7:1])};
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("bit not shifted in at the top");

  property p_count_range;
    @(posedge clk) disable iff (reset)
    count_reg <= RRX_LAST_BIT;
  endproperty
  a_count_range: assert property (p_count_range)
    else $error("bit count beyond seven");

  property p_err_clear;
    @(posedge clk) disable iff (reset)
    enable && frameError |=> count_reg == 8'h00;
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("error did not clear count");

  property p_read_clear;
    @(posedge clk) disable iff (reset)
    enable && shiftRd && frame_reg == RRX_ENDED |=> count_reg == 8'h00;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("shifter read after end kept count");

  property p_end_keeps_count;
    @(posedge clk) disable iff (reset)
    quiet && frameEnd && !bitValid ##1 quiet && !bitValid && !shiftRd
      |-> count_reg == $past(count_reg, 1);
  endproperty
  a_end_keeps_count: assert property (p_end_keeps_count)
    else $error("frame end disturbed the count");

  property p_count_read;
    @(posedge clk) disable iff (reset)
    regRd && hit(regAddr, RRX_OFF_COUNT) |=> regRdData == $past(count_reg);
  endproperty
  a_count_read: assert property (p_count_read)
    else $error("count read returned wrong value");

  property p_hold_read;
    @(posedge clk) disable iff (reset)
    regRd && hit(regAddr, RRX_OFF_HOLD) |=> regRdData == $past(hold_reg);
  endproperty
  a_hold_read: assert property (p_hold_read)
    else $error("holding read returned wrong value");

  property p_no_write;
    @(posedge clk) disable iff (reset)
    regWr && (hit(regAddr, RRX_OFF_HOLD) || hit(regAddr, RRX_OFF_COUNT))
      && !bitValid && quiet |=> $stable(hold_reg) && $stable(count_reg);
  endproperty
  a_no_write: assert property (p_no_write)
    else $error("read-only register took a write");

  // event is latched in status at the same edge as the pulse
  property p_full_status;
    @(posedge clk) disable iff (reset)
    byteFull |-> core.statusVal[RRX_EV_FULL];
  endproperty
  a_full_status: assert property (p_full_status)
    else $error("byte-full event not latched in status");

  property p_irq_level;
    @(posedge clk) disable iff (reset)
    byteFull && core.maskVal[RRX_EV_FULL] |-> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("unmasked byte-full did not raise interrupt");
endmodule
`default_nettype wire

// ==== hw/rrx_pkg.sv ====
// constants, offsets and types shared by the remote receive data path
`default_nettype none
package rrx_pkg;
  localparam int RRX_ADDR_W = 4;
  localparam int RRX_BYTE_W = 8;
  localparam logic [7:0] RRX_LAST_BIT = 8'h07;
  localparam logic [3:0] RRX_OFF_HOLD = 4'h0;
  localparam logic [3:0] RRX_OFF_COUNT = 4'h1;
  localparam logic [3:0] RRX_OFF_SHIFT = 4'h2;
  localparam logic [3:0] RRX_OFF_CTRL = 4'h3;
  localparam logic [3:0] RRX_OFF_STATUS = 4'h4;
  localparam logic [3:0] RRX_OFF_MASK = 4'h5;
  localparam logic [7:0] RRX_RST_BYTE = 8'h00;
  localparam logic [7:0] RRX_RST_COUNT = 8'h00;
  localparam logic [7:0] RRX_RST_SHIFT = 8'h00;
  localparam logic [7:0] RRX_RST_CTRL = 8'h00;
  localparam logic [7:0] RRX_RST_STATUS = 8'h00;
  localparam logic [7:0] RRX_RST_MASK = 8'h00;
  localparam logic [7:0] RRX_RD_IDLE = 8'h00;
  localparam int RRX_CTRL_EN = 0;
  localparam int RRX_EV_FULL = 0;
  localparam int RRX_EV_END = 1;
  localparam int RRX_EV_ERR = 2;
  localparam int RRX_NUM_EV = 3;
  typedef enum logic [1:0]
  {
    RRX_IDLE = 2'b00,
    RRX_RECV = 2'b01,
    RRX_ENDED = 2'b11
  } rrx_frame_t;
endpackage
`default_nettype wire

// ==== hw/rrx_core_if.sv ====
// carrier between the data path top and its status and read-port blocks
`default_nettype none
interface rrx_core_if;
  import rrx_pkg::*;
  logic [RRX_NUM_EV-1:0] evt;
  logic wrStatus;
  logic wrMask;
  logic [7:0] wrData;
  logic [7:0] statusVal;
  logic [7:0] maskVal;
  logic rdStrobe;
  logic [RRX_ADDR_W-1:0] rdAddr;
  logic [7:0] holdVal;
  logic [7:0] countVal;
  logic [7:0] shiftVal;
  logic [7:0] ctrlVal;
  logic [7:0] rdData;
  modport top(output evt, wrStatus, wrMask, wrData, rdStrobe, rdAddr, holdVal,
    countVal, shiftVal, ctrlVal, input statusVal, maskVal, rdData);
  modport irqm(input evt, wrStatus, wrMask, wrData, output statusVal, maskVal);
  modport rdm(input rdStrobe, rdAddr, holdVal, countVal, shiftVal, ctrlVal,
    statusVal, maskVal, output rdData);
endinterface
`default_nettype wire

// ==== hw/rrx_irq_status.sv ====
// sticky event status, mask and level interrupt
`default_nettype none
module rrx_irq_status #(
  parameter int NUM_EV = rrx_pkg::RRX_NUM_EV
) (
  input wire logic clk,
  input wire logic reset,
  rrx_core_if.irqm bus,
  output logic irq
);
  import rrx_pkg::*;
  logic [NUM_EV-1:0] status_reg;
  logic [NUM_EV-1:0] status_next;
  logic [NUM_EV-1:0] mask_reg;
  logic [NUM_EV-1:0] mask_next;

  if (NUM_EV != RRX_NUM_EV)
  begin : g_bad
    $error("event count must match the carrier");
  end

  always_comb
  begin
    // set wins over a write-one clear in the same cycle
    status_next = (status_reg & ~(bus.wrStatus ? bus.wrData[NUM_EV-1:0] : '0))
      | bus.evt;
    mask_next = bus.wrMask ? bus.wrData[NUM_EV-1:0] : mask_reg;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      status_reg <= RRX_RST_STATUS[NUM_EV-1:0];
      mask_reg <= RRX_RST_MASK[NUM_EV-1:0];
    end
    else
    begin
      status_reg <= status_next;
      mask_reg <= mask_next;
    end
  end

  assign bus.statusVal = {{(8 - NUM_EV){1'b0}}, status_reg};
  assign bus.maskVal = {{(8 - NUM_EV){1'b0}}, mask_reg};
  assign irq = |(status_reg & mask_reg);
endmodule
`default_nettype wire

// ==== hw/rrx_read_port.sv ====
// registered read data for the software port
`default_nettype none
module rrx_read_port (
  input wire logic clk,
  input wire logic reset,
  rrx_core_if.rdm bus
);
  import rrx_pkg::*;
  logic [7:0] rdData_reg;
  logic [7:0] rdData_next;

  always_comb
  begin
    rdData_next = RRX_RD_IDLE;
    if (!bus.rdStrobe)
      rdData_next = RRX_RD_IDLE;
    else if (bus.rdAddr == RRX_OFF_HOLD)
      rdData_next = bus.holdVal;
    else if (bus.rdAddr == RRX_OFF_COUNT)
      rdData_next = bus.countVal;
    else if (bus.rdAddr == RRX_OFF_SHIFT)
      rdData_next = bus.shiftVal;
    else if (bus.rdAddr == RRX_OFF_CTRL)
      rdData_next = bus.ctrlVal;
    else if (bus.rdAddr == RRX_OFF_STATUS)
      rdData_next = bus.statusVal;
    else if (bus.rdAddr == RRX_OFF_MASK)
      rdData_next = bus.maskVal;
    else
      rdData_next = RRX_RD_IDLE;
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (reset)
      rdData_reg <= RRX_RD_IDLE;
    else
      rdData_reg <= rdData_next;
  end

  assign bus.rdData = rdData_reg;
endmodule
`default_nettype wire

// ==== tb/rrx_bit_source.sv ====
// decoder-side model: feeds bits and frame events into the data path
`default_nettype none
module rrx_bit_source (
  input wire logic clk,
  output logic bitValid,
  output logic bitValue,
  output logic frameEnd,
  output logic frameError
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    bitValid = 1'b0;
    bitValue = 1'b1;
    frameEnd = 1'b0;
    frameError = 1'b0;
  end
  // idle data line shows the inverse of the last bit, except after a send with a gap, where it ends showing that bit again
  task automatic send(input logic [15:0] bits, input int n, input int gap);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      bitValid <= 1'b1;
      bitValue <= bits[i];
      repeat (gap)
      begin
        @(posedge clk);
        bitValid <= 1'b0;
        bitValue <= ~bits[i];
      end
    end
    @(posedge clk);
    bitValid <= 1'b0;
    bitValue <= ~bitValue;
  endtask
  task automatic pulse(input logic isErr);
    @(posedge clk);
    frameEnd <= ~isErr;
    frameError <= isErr;
    @(posedge clk);
    frameEnd <= 1'b0;
    frameError <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/test_rrx_data_path.sv ====
// self-checking bench for the remote receive data path
`default_nettype none
module test_rrx_data_path;
  timeunit 1ns;
  timeprecision 100ps;
  import rrx_pkg::*;
  logic clk;
  logic reset;
  logic regWr;
  logic regRd;
  logic [RRX_ADDR_W-1:0] regAddr;
  logic [7:0] regWrData;
  wire logic [7:0] regRdData;
  wire logic byteFull;
  wire logic irq;
  wire logic bitValid;
  wire logic bitValue;
  wire logic frameEnd;
  wire logic frameError;
  int n_fail = 0;
  int n_tests = 0;
  int seed = 91;
  int cycles = 0;
  logic pend = 1'b0;
  logic [7:0] expRd[$];
  logic [7:0] expFull[$];
  logic [7:0] sh;
  logic [7:0] b;
  logic [15:0] w;

  rrx_data_path rrx_data_path_inst (.clk(clk), .reset(reset), .bitValid(bitValid),
    .bitValue(bitValue), .frameEnd(frameEnd), .frameError(frameError), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .byteFull(byteFull), .irq(irq));
  rrx_bit_source rrx_bit_source_inst (.clk(clk), .bitValid(bitValid), .bitValue(bitValue),
    .frameEnd(frameEnd), .frameError(frameError));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_irq(input logic e);
    @(negedge clk);
    chk({7'h00, irq}, {7'h00, e});
  endtask

  task automatic wr(input logic [RRX_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [RRX_ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    expRd.push_back(e);
    @(posedge clk);
    regRd <= 1'b0;
  endtask

  // read data only in the cycle after the strobe, idle value otherwise
  always @(posedge clk)
  begin
    if (pend)
      chk(regRdData, expRd.pop_front());
    else if (!reset)
      chk(regRdData, RRX_RD_IDLE);
    // flops are unknown before the first reset edge
    if (!reset && byteFull !== 1'b0)
    begin
      chk(8'(expFull.size() > 0), 8'h01);
      if (expFull.size() > 0)
        chk(rrx_data_path_inst.hold_reg, expFull.pop_front());
    end
    pend = regRd;
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      final_report();
    end
  end

  initial
  begin
    reset = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = '0;
    regWrData = 8'h00;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a < 6; a++) rd(a[RRX_ADDR_W-1:0], 8'h00);
    rd(4'hf, 8'h00);
    for (int a = 0; a < 3; a++) wr(a[RRX_ADDR_W-1:0], 8'hff);
    for (int a = 0; a < 3; a++) rd(a[RRX_ADDR_W-1:0], 8'h00);
    rrx_bit_source_inst.send(16'h0007, 3, 0);
    rd(RRX_OFF_COUNT, 8'h00);
    wr(RRX_OFF_CTRL, 8'h01);
    // one byte, bit by bit, watching count and shifter
    b = 8'($random(seed));
    sh = 8'h00;
    expFull.push_back(b);
    for (int i = 0; i < 8; i++)
    begin
      rrx_bit_source_inst.send({15'h0000, b[i]}, 1, 0);
      sh = {b[i], sh[7:1]};
      if (i < 7)
      begin
        rd(RRX_OFF_COUNT, 8'(i + 1));
        rd(RRX_OFF_SHIFT, sh);
      end
    end
    rd(RRX_OFF_COUNT, 8'h00);
    rd(RRX_OFF_SHIFT, 8'h00);
    rd(RRX_OFF_HOLD, b);
    chk_irq(1'b0);
    rd(RRX_OFF_STATUS, 8'h01);
    wr(RRX_OFF_MASK, 8'h01);
    chk_irq(1'b1);
    wr(RRX_OFF_STATUS, 8'h01);
    chk_irq(1'b0);
    // two bytes back to back, the first never read
    w = 16'($random(seed));
    expFull.push_back(w[7:0]);
    expFull.push_back(w[15:8]);
    rrx_bit_source_inst.send(w, 16, 0);
    rd(RRX_OFF_HOLD, w[15:8]);
    wr(RRX_OFF_STATUS, 8'h07);
    // short frame with a slow decoder
    w = 16'($random(seed));
    rrx_bit_source_inst.send(w, 3, 1 + ($random(seed) & 1));
    rrx_bit_source_inst.pulse(1'b0);
    rd(RRX_OFF_COUNT, 8'h03);
    rd(RRX_OFF_SHIFT, {w[2:0], 5'h00});
    rd(RRX_OFF_COUNT, 8'h00);
    rd(RRX_OFF_SHIFT, 8'h00);
    rd(RRX_OFF_STATUS, 8'h02);
    chk_irq(1'b0);
    wr(RRX_OFF_STATUS, 8'h07);
    // error in mid-byte
    rrx_bit_source_inst.send(w, 5, 0);
    rrx_bit_source_inst.pulse(1'b1);
    rd(RRX_OFF_COUNT, 8'h00);
    rd(RRX_OFF_SHIFT, 8'h00);
    rd(RRX_OFF_STATUS, 8'h04);
    // disable with a byte held and bits pending
    b = 8'($random(seed)) | 8'h01;
    expFull.push_back(b);
    rrx_bit_source_inst.send({8'h00, b}, 8, 0);
    rd(RRX_OFF_HOLD, b);
    rrx_bit_source_inst.send(w, 4, 0);
    // writes to read-only registers while receiving
    wr(RRX_OFF_HOLD, 8'hff);
    wr(RRX_OFF_COUNT, 8'hff);
    rd(RRX_OFF_HOLD, b);
    rd(RRX_OFF_COUNT, 8'h04);
    wr(RRX_OFF_CTRL, 8'h00);
    rd(RRX_OFF_HOLD, 8'h00);
    rd(RRX_OFF_COUNT, 8'h00);
    rd(RRX_OFF_SHIFT, 8'h00);
    // reset in mid-run
    wr(RRX_OFF_CTRL, 8'h01);
    expFull.push_back(8'h5a);
    rrx_bit_source_inst.send(16'h005a, 10, 0);
    @(posedge clk);
    reset <= 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rd(RRX_OFF_HOLD, 8'h00);
    rd(RRX_OFF_COUNT, 8'h00);
    rd(RRX_OFF_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    chk(8'(expFull.size()), 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
